// ==== verilog/cta_counter_array.v ====
// shared 16-bit counter of the counter array with its timebase, flags and request
`timescale 1ns/1ns
`include "cta_consts.vh"

module cta_counter_array #(
  parameter HAS_SLOW_OSC = 1
) (
  // clock and reset
  input  wire        clk_i,
  input  wire        rst_i,
  // wishbone classic slave
  input  wire        cyc_i,
  input  wire        stb_i,
  input  wire        we_i,
  input  wire [7:0]  adr_i,
  input  wire [3:0]  sel_i,
  input  wire [31:0] dat_i,
  output wire [31:0] dat_o,
  output wire        ack_o,
  // count sources
  input  wire        idle_i,
  input  wire        timer0_ovf_i,
  input  wire        external_count_input_i,
  input  wire        ext_osc_i,
  input  wire        slow_osc_i,
  // channel side
  input  wire [5:0]  channel_event_i,
  output wire [15:0] count_o,
  output wire        counter_tick_o,
  output wire        watchdog_mode_o,
  // request to the processor interrupt logic
  output wire        irq_o
);

  // ==========================================================================
  // storage
  reg        ack_reg;
  reg [31:0] dat_reg;
  reg        idle_suspend_reg;
  reg [2:0]  timebase_select_reg;
  reg        overflow_irq_enable_reg;
  reg        intermediate_overflow_enable_reg;
  reg [1:0]  cycle_length_select_reg;
  reg        watchdog_mode_reg;
  reg        counter_overflow_flag_reg;
  reg        intermediate_overflow_flag_reg;
  reg [5:0]  channel_event_flag_reg;
  reg [5:0]  channel_event_enable_reg;
  reg [15:0] count_reg;
  reg [15:0] count_next;
  reg [7:0]  snapshot_reg;
  reg [3:0]  presc_reg;
  reg        div12_tick_reg;
  reg        div4_tick_reg;
  reg        tick_reg;
  reg        irq_reg;

  wire       ext_edge_tick;
  wire       ext_osc_tick;
  wire       slow_osc_tick;
  wire       bus_req;
  wire       bus_wr;
  wire       bus_rd;
  wire       run_ok;
  reg        tb_tick;
  wire       count_step;
  wire       wrap_full;
  wire       wrap_mid;
  wire       hit_ctrl;
  wire       hit_flags;
  wire       hit_chen;
  wire       hit_low;
  wire       hit_high;

  // ==========================================================================
  // helper functions

  // true when the address selects the given register offset
  function addr_hit;
    input [7:0] adr;
    input [7:0] ofs;
    begin
      addr_hit = (adr == ofs);
    end
  endfunction

  // true when the low 8..11 bits are all ones, so the next step carries out
  function mid_carry;
    input [15:0] cnt;
    input [1:0]  cls;
    begin
      case (cls)
        2'h0:    mid_carry = &cnt[7:0];
        2'h1:    mid_carry = &cnt[8:0];
        2'h2:    mid_carry = &cnt[9:0];
        2'h3:    mid_carry = &cnt[10:0];
        default: mid_carry = 1'b0;
      endcase
    end
  endfunction

  // ==========================================================================
  // bus decode; one wait-free answer, ack one cycle after the request appears
  assign bus_req   = cyc_i & stb_i & ~ack_reg;
  assign bus_wr    = bus_req & we_i;
  assign bus_rd    = bus_req & ~we_i;
  assign hit_ctrl  = addr_hit(adr_i, `CTA_OFS_CTRL);
  assign hit_flags = addr_hit(adr_i, `CTA_OFS_FLAGS);
  assign hit_chen  = addr_hit(adr_i, `CTA_OFS_CH_ENABLE);
  assign hit_low   = addr_hit(adr_i, `CTA_OFS_COUNT_LOW);
  assign hit_high  = addr_hit(adr_i, `CTA_OFS_COUNT_HIGH);

  // acknowledge every access, mapped or not; drop it the cycle after
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= bus_req;
    end
  end

  // ==========================================================================
  // sources that need synchronizing

  // count input: falling edges, one tick each
  cta_edge_tick #(
    .DIV_LAST (`CTA_EDGE_DIV_LAST),
    .FALLING  (1)
  ) u_ext_edge (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .src_i  (external_count_input_i),
    .tick_o (ext_edge_tick)
  );

  // external oscillator divided by eight after synchronizing
  cta_edge_tick #(
    .DIV_LAST (`CTA_OSC_DIV_LAST),
    .FALLING  (0)
  ) u_ext_osc (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .src_i  (ext_osc_i),
    .tick_o (ext_osc_tick)
  );

  // slow oscillator divided by eight after synchronizing
  cta_edge_tick #(
    .DIV_LAST (`CTA_OSC_DIV_LAST),
    .FALLING  (0)
  ) u_slow_osc (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .src_i  (slow_osc_i),
    .tick_o (slow_osc_tick)
  );

  // ==========================================================================
  // clock prescaler; one counter serves both divide ratios
  always @(posedge clk_i) begin
    if (rst_i) begin
      presc_reg      <= 4'h0;
      div12_tick_reg <= 1'b0;
      div4_tick_reg  <= 1'b0;
    end else begin
      if (presc_reg == `CTA_DIV12_LAST) begin
        presc_reg <= 4'h0;
      end else begin
        presc_reg <= presc_reg + 4'h1;
      end
      div12_tick_reg <= (presc_reg == `CTA_DIV12_LAST);
      div4_tick_reg  <= ((presc_reg & `CTA_DIV4_LAST) == `CTA_DIV4_LAST);
    end
  end

  // ==========================================================================
  // timebase selection; reserved codes never count
  always @* begin
    case (timebase_select_reg)
      `CTA_TB_DIV12:    tb_tick = div12_tick_reg;
      `CTA_TB_DIV4:     tb_tick = div4_tick_reg;
      `CTA_TB_TIMER0:   tb_tick = timer0_ovf_i;
      `CTA_TB_EXT_EDGE: tb_tick = ext_edge_tick;
      `CTA_TB_SYSCLK:   tb_tick = 1'b1;
      `CTA_TB_EXT_OSC:  tb_tick = ext_osc_tick;
      `CTA_TB_SLOW_OSC: tb_tick = (HAS_SLOW_OSC != 0) & slow_osc_tick;
      default:          tb_tick = 1'b0;
    endcase
  end

  // idle only stops counting when suspend is asked for
  assign run_ok     = ~(idle_suspend_reg & idle_i);
  assign count_step = tb_tick & run_ok;
  assign wrap_full  = count_step & (&count_reg);
  assign wrap_mid   = count_step & mid_carry(count_reg, cycle_length_select_reg);

  // ==========================================================================
  // counter next value; a software write wins over a tick in the same cycle
  // and the watchdog guard blocks such writes entirely
  always @* begin
    count_next = count_reg;
    if (count_step) begin
      count_next = count_reg + 16'h0001;
    end
    if (bus_wr & ~watchdog_mode_reg & sel_i[0] & hit_low) begin
      count_next = {count_reg[15:8], dat_i[7:0]};
    end
    if (bus_wr & ~watchdog_mode_reg & sel_i[0] & hit_high) begin
      count_next = {dat_i[7:0], count_reg[7:0]};
    end
  end

  // counter register; reads do not appear here at all
  always @(posedge clk_i) begin
    if (rst_i) begin
      count_reg <= `CTA_RST_COUNT;
      tick_reg  <= 1'b0;
    end else begin
      count_reg <= count_next;
      tick_reg  <= count_step;
    end
  end

  // ==========================================================================
  // snapshot of the high byte, taken when the low byte is read
  always @(posedge clk_i) begin
    if (rst_i) begin
      snapshot_reg <= 8'h00;
    end else if (bus_rd & hit_low) begin
      snapshot_reg <= count_reg[15:8];
    end
  end

  // ==========================================================================
  // control register; while the watchdog runs only its own bit may be written
  always @(posedge clk_i) begin
    if (rst_i) begin
      idle_suspend_reg                 <= 1'b0;
      timebase_select_reg              <= `CTA_RST_TIMEBASE;
      overflow_irq_enable_reg          <= 1'b0;
      intermediate_overflow_enable_reg <= 1'b0;
      cycle_length_select_reg          <= `CTA_RST_CLS;
      watchdog_mode_reg                <= `CTA_RST_WDT;
    end else if (bus_wr & hit_ctrl) begin
      if (sel_i[0] & ~watchdog_mode_reg) begin
        idle_suspend_reg                 <= dat_i[`CTA_CTRL_IDLE_BIT];
        timebase_select_reg              <= dat_i[`CTA_CTRL_TB_MSB:`CTA_CTRL_TB_LSB];
        overflow_irq_enable_reg          <= dat_i[`CTA_CTRL_OVF_EN_BIT];
        intermediate_overflow_enable_reg <= dat_i[`CTA_CTRL_IOV_EN_BIT];
        cycle_length_select_reg          <= dat_i[`CTA_CTRL_CLS_MSB:`CTA_CTRL_CLS_LSB];
      end
      if (sel_i[1]) begin
        watchdog_mode_reg <= dat_i[`CTA_CTRL_WDT_BIT];
      end
    end
  end

  // channel enable register
  always @(posedge clk_i) begin
    if (rst_i) begin
      channel_event_enable_reg <= 6'h00;
    end else if (bus_wr & hit_chen & sel_i[0]) begin
      channel_event_enable_reg <= dat_i[5:0];
    end
  end

  // ==========================================================================
  // event flags: set by their trigger whatever the enables say, cleared only
  // by writing one; a trigger in the clearing cycle keeps the flag set
  always @(posedge clk_i) begin
    if (rst_i) begin
      counter_overflow_flag_reg      <= 1'b0;
      intermediate_overflow_flag_reg <= 1'b0;
    end else begin
      if (wrap_full) begin
        counter_overflow_flag_reg <= 1'b1;
      end else if (bus_wr & hit_flags & sel_i[0] & dat_i[`CTA_FLAG_OVF_BIT]) begin
        counter_overflow_flag_reg <= 1'b0;
      end
      if (wrap_mid) begin
        intermediate_overflow_flag_reg <= 1'b1;
      end else if (bus_wr & hit_flags & sel_i[0] & dat_i[`CTA_FLAG_IOV_BIT]) begin
        intermediate_overflow_flag_reg <= 1'b0;
      end
    end
  end

  // one flag per channel, built the same way
  genvar ch;
  generate
    for (ch = 0; ch < 6; ch = ch + 1) begin : g_chflag
      always @(posedge clk_i) begin
        if (rst_i) begin
          channel_event_flag_reg[ch] <= 1'b0;
        end else if (channel_event_i[ch]) begin
          channel_event_flag_reg[ch] <= 1'b1;
        end else if (bus_wr & hit_flags & sel_i[0] & dat_i[`CTA_FLAG_CH_LSB + ch]) begin
          channel_event_flag_reg[ch] <= 1'b0;
        end
      end
    end
  endgenerate

  // ==========================================================================
  // combined request; the processor adds its own global and array enables
  always @(posedge clk_i) begin
    if (rst_i) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= (counter_overflow_flag_reg & overflow_irq_enable_reg)
               | (intermediate_overflow_flag_reg & intermediate_overflow_enable_reg)
               | (|(channel_event_flag_reg & channel_event_enable_reg));
    end
  end

  // ==========================================================================
  // read data, registered together with ack; unmapped reads give zero
  always @(posedge clk_i) begin
    if (rst_i) begin
      dat_reg <= `CTA_RST_DATA;
    end else if (bus_rd) begin
      dat_reg <= `CTA_RST_DATA;
      if (hit_ctrl) begin
        dat_reg[`CTA_CTRL_IDLE_BIT]                  <= idle_suspend_reg;
        dat_reg[`CTA_CTRL_TB_MSB:`CTA_CTRL_TB_LSB]   <= timebase_select_reg;
        dat_reg[`CTA_CTRL_OVF_EN_BIT]                <= overflow_irq_enable_reg;
        dat_reg[`CTA_CTRL_IOV_EN_BIT]                <= intermediate_overflow_enable_reg;
        dat_reg[`CTA_CTRL_CLS_MSB:`CTA_CTRL_CLS_LSB] <= cycle_length_select_reg;
        dat_reg[`CTA_CTRL_WDT_BIT]                   <= watchdog_mode_reg;
      end
      if (hit_flags) begin
        dat_reg[`CTA_FLAG_OVF_BIT]                   <= counter_overflow_flag_reg;
        dat_reg[`CTA_FLAG_IOV_BIT]                   <= intermediate_overflow_flag_reg;
        dat_reg[`CTA_FLAG_CH_MSB:`CTA_FLAG_CH_LSB]   <= channel_event_flag_reg;
      end
      if (hit_chen) begin
        dat_reg[5:0] <= channel_event_enable_reg;
      end
      if (hit_low) begin
        dat_reg[7:0] <= count_reg[7:0];
      end
      if (hit_high) begin
        dat_reg[7:0] <= snapshot_reg;
      end
    end
  end

  // ==========================================================================
  // outputs, all straight from flops
  assign ack_o           = ack_reg;
  assign dat_o           = dat_reg;
  assign count_o         = count_reg;
  assign counter_tick_o  = tick_reg;
  assign watchdog_mode_o = watchdog_mode_reg;
  assign irq_o           = irq_reg;

endmodule

// ==== verilog/cta_consts.vh ====
// constants for the counter array timebase, overflow flags and interrupt request
// ============================================================================
// ============================================================================
`ifndef CTA_CONSTS_VH
`define CTA_CONSTS_VH

// ============================================================================
// register byte offsets
`define CTA_OFS_CTRL        8'h00
`define CTA_OFS_FLAGS       8'h04
`define CTA_OFS_CH_ENABLE   8'h08
`define CTA_OFS_COUNT_LOW   8'h0C
`define CTA_OFS_COUNT_HIGH  8'h10

// ============================================================================
// control register field positions
`define CTA_CTRL_IDLE_BIT   0
`define CTA_CTRL_TB_LSB     1
`define CTA_CTRL_TB_MSB     3
`define CTA_CTRL_OVF_EN_BIT 4
`define CTA_CTRL_IOV_EN_BIT 5
`define CTA_CTRL_CLS_LSB    6
`define CTA_CTRL_CLS_MSB    7
`define CTA_CTRL_WDT_BIT    8

// flag register field positions
`define CTA_FLAG_OVF_BIT    0
`define CTA_FLAG_IOV_BIT    1
`define CTA_FLAG_CH_LSB     2
`define CTA_FLAG_CH_MSB     7

// ============================================================================
// reset values
`define CTA_RST_TIMEBASE    3'h0
`define CTA_RST_CLS         2'h0
`define CTA_RST_WDT         1'b1
`define CTA_RST_COUNT       16'h0000
`define CTA_RST_DATA        32'h0000_0000

// ============================================================================
// timebase codes
`define CTA_TB_DIV12        3'h0
`define CTA_TB_DIV4         3'h1
`define CTA_TB_TIMER0       3'h2
`define CTA_TB_EXT_EDGE     3'h3
`define CTA_TB_SYSCLK       3'h4
`define CTA_TB_EXT_OSC      3'h5
`define CTA_TB_SLOW_OSC     3'h6

// ============================================================================
// timing counts
`define CTA_DIV12_LAST      4'hB
`define CTA_DIV4_LAST       4'h3
`define CTA_OSC_DIV_LAST    3'h7
`define CTA_EDGE_DIV_LAST   3'h0

`endif

// ==== verilog/cta_edge_tick.v ====
// synchronizer, edge detector and modulo divider giving one-cycle ticks
`timescale 1ns/1ns
`include "cta_consts.vh"

module cta_edge_tick #(
  parameter [2:0] DIV_LAST = 3'h0,
  parameter       FALLING  = 0
) (
  // clock and reset
  input  wire clk_i,
  input  wire rst_i,
  // source and result
  input  wire src_i,
  output wire tick_o
);

  reg       sync1_reg;
  reg       sync2_reg;
  reg       prev_reg;
  reg [2:0] div_reg;
  reg       tick_reg;
  wire      edge_seen;

  // two flops before any logic looks at the source; the first feeds only the second
  always @(posedge clk_i) begin
    if (rst_i) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      prev_reg  <= 1'b0;
    end else begin
      sync1_reg <= src_i;
      sync2_reg <= sync1_reg;
      prev_reg  <= sync2_reg;
    end
  end

  // edge taken from synchronized samples only, one pulse per edge
  assign edge_seen = (FALLING != 0) ? (prev_reg & ~sync2_reg)
                                    : (~prev_reg & sync2_reg);

  // divide edges; a tick leaves every DIV_LAST+1 edges
  always @(posedge clk_i) begin
    if (rst_i) begin
      div_reg  <= 3'h0;
      tick_reg <= 1'b0;
    end else begin
      tick_reg <= 1'b0;
      if (edge_seen) begin
        if (div_reg == DIV_LAST) begin
          div_reg  <= 3'h0;
          tick_reg <= 1'b1;
        end else begin
          div_reg <= div_reg + 3'h1;
        end
      end
    end
  end

  assign tick_o = tick_reg;

endmodule

// ==== verif/cta_counter_array_assertions.sv ====
// checker for counter stepping, timebase, idle hold, flags and request
`timescale 1ns/1ns
`include "cta_consts.vh"

module cta_counter_array_assertions (
  // clock and reset
  input wire        clk_i,
  input wire        rst_i,
  // bus
  input wire        cyc_i,
  input wire        stb_i,
  input wire        we_i,
  input wire [7:0]  adr_i,
  input wire [3:0]  sel_i,
  input wire [31:0] dat_i,
  input wire        ack_o,
  // sources and results
  input wire        idle_i,
  input wire [5:0]  channel_event_i,
  input wire [15:0] count_o,
  input wire        counter_tick_o,
  input wire        watchdog_mode_o,
  input wire        irq_o
);
  // ==========================================================================
  // shadow of the configuration, kept from the bus writes
  reg  [7:0] ctl_reg;
  reg  [5:0] che_reg;
  wire       take   = cyc_i && stb_i && we_i && !ack_o && sel_i[0];
  wire       stop   = ctl_reg[0] && idle_i;
  wire       run4   = ctl_reg[3:1] == `CTA_TB_SYSCLK && !stop;
  wire       en_any = |{ctl_reg[5:4], che_reg};

  // lane0 control writes are dropped while the watchdog is on
  always @(posedge clk_i) begin
    if (rst_i) begin
      ctl_reg <= 8'h00;
      che_reg <= 6'h00;
    end else if (take && adr_i == `CTA_OFS_CTRL && !watchdog_mode_o) begin
      ctl_reg <= dat_i[7:0];
    end else if (take && adr_i == `CTA_OFS_CH_ENABLE) begin
      che_reg <= dat_i[5:0];
    end
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // ==========================================================================
  // properties
  // two cycles of the same state so a pipelined tick is not misjudged
  sequence s_run; run4 && $past(run4) ##1 !ack_o; endsequence
  sequence s_held; stop && $past(stop) ##1 !ack_o; endsequence

  property p_step; !ack_o && count_o != $past(count_o) |-> count_o == $past(count_o) + 16'h0001;
  endproperty
  a_step: assert property (p_step) else $error("count moved by other than one");
  property p_sysclk; s_run |-> count_o == $past(count_o) + 16'h0001; endproperty
  a_sysclk: assert property (p_sysclk) else $error("count missed a clock");
  property p_idle; s_held |-> $stable(count_o); endproperty
  a_idle: assert property (p_idle) else $error("count moved in idle");
  property p_wrap; ctl_reg[4] && !ack_o && count_o == 16'h0000 && $past(count_o) == 16'hFFFF
    |-> ##[1:2] irq_o; endproperty
  a_wrap: assert property (p_wrap) else $error("wrap gave no request");
  property p_mask; !en_any && !$past(en_any) |-> !irq_o; endproperty
  a_mask: assert property (p_mask) else $error("request with no enable");
  property p_chan; channel_event_i[0] && che_reg[0] |-> ##[1:2] irq_o; endproperty
  a_chan: assert property (p_chan) else $error("channel event gave no request");
  property p_hold; irq_o && !we_i && !$past(we_i) |=> irq_o; endproperty
  a_hold: assert property (p_hold) else $error("request dropped by itself");
  property p_wdog; watchdog_mode_o && !(cyc_i && stb_i && we_i && sel_i[1]) |=> watchdog_mode_o;
  endproperty
  a_wdog: assert property (p_wdog) else $error("watchdog left by itself");
  // with no counter write behind it, the step pulse marks exactly the cycles the count moved
  property p_tick; !ack_o |-> counter_tick_o == (count_o != $past(count_o)); endproperty
  a_tick: assert property (p_tick) else $error("step pulse out of line with count");
endmodule

bind cta_counter_array cta_counter_array_assertions chk_u (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
  .sel_i(sel_i), .dat_i(dat_i), .ack_o(ack_o), .idle_i(idle_i),
  .channel_event_i(channel_event_i), .count_o(count_o), .counter_tick_o(counter_tick_o),
  .watchdog_mode_o(watchdog_mode_o),
  .irq_o(irq_o)
);

// ==== verif/cta_src_model.sv ====
// source model for the count inputs: two oscillators and the count line
`timescale 1ns/1ns

module cta_src_model (
  // clock
  input  wire clk_i,
  // sources, parked low (oscillators) and high (count line) between bursts
  output reg  ext_osc_o  = 1'b0,
  output reg  slow_osc_o = 1'b0,
  output reg  count_in_o = 1'b1
);
  // n pulses, each level held two clocks, so never faster than a quarter of clk
  task automatic burst(input integer w, input integer n);
    repeat (2 * n) begin
      repeat (2) @(posedge clk_i);
      if (w == 0)
        ext_osc_o <= ~ext_osc_o;
      else if (w == 1)
        slow_osc_o <= ~slow_osc_o;
      else
        count_in_o <= ~count_in_o;
    end
  endtask
endmodule

// ==== verif/cta_counter_array_tb.sv ====
// self-checking bench for the counter array timebase, flags and request
`timescale 1ns/1ns
`include "cta_consts.vh"

module cta_counter_array_tb;
  // ==========================================================================
  // signals
  reg         clk_i = 1'b0, rst_i = 1'b1, idle_i = 1'b0, timer0_ovf_i = 1'b0;
  reg         cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
  reg  [7:0]  adr_i = 8'h00;
  reg  [3:0]  sel_i = 4'h0;
  reg  [31:0] dat_i = 32'h0000_0000;
  reg  [5:0]  channel_event_i = 6'h00;
  wire [31:0] dat_o;
  wire [15:0] count_o;
  wire        ack_o, ext_osc, slow_osc, count_in, watchdog_mode_o, irq_o;
  integer     bad_count = 0;
  integer     checks = 0;
  integer     i;
  reg  [31:0] rd;

  // 100 MHz system clock
  always #5 clk_i = ~clk_i;

  cta_counter_array dut_u (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .idle_i(idle_i), .timer0_ovf_i(timer0_ovf_i), .external_count_input_i(count_in),
    .ext_osc_i(ext_osc), .slow_osc_i(slow_osc), .channel_event_i(channel_event_i),
    .count_o(count_o), .counter_tick_o(), .watchdog_mode_o(watchdog_mode_o), .irq_o(irq_o)
  );

  cta_src_model src_u (
    .clk_i(clk_i), .ext_osc_o(ext_osc), .slow_osc_o(slow_osc), .count_in_o(count_in)
  );

  // ==========================================================================
  // tasks
  task automatic chk(input [31:0] got, input [31:0] exp);
    checks = checks + 1;
    if (got !== exp) begin
      bad_count = bad_count + 1;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  // one classic cycle; the request stands until ack is seen at a rising edge,
  // read data is taken at that same edge and only then is the request dropped
  task automatic xfer(input bit w, input [7:0] a, input [3:0] s, input [31:0] d);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    sel_i <= s;
    dat_i <= d;
    @(posedge clk_i);
    while (ack_o !== 1'b1) @(posedge clk_i);
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
  endtask

  task automatic wr(input [7:0] a, input [31:0] d);
    xfer(1'b1, a, 4'h1, d);
  endtask

  task automatic rdchk(input [7:0] a, input [31:0] exp);
    xfer(1'b0, a, 4'h1, 32'h0000_0000);
    chk(rd, exp);
  endtask

  task automatic setc(input [15:0] v);
    wr(`CTA_OFS_COUNT_LOW, {24'h00_0000, v[7:0]});
    wr(`CTA_OFS_COUNT_HIGH, {24'h00_0000, v[15:8]});
  endtask

  // n timer0 pulses, then two cycles so flags and request have landed
  task automatic tick0(input integer n);
    repeat (n) begin
      @(posedge clk_i);
      timer0_ovf_i <= 1'b1;
      @(posedge clk_i);
      timer0_ovf_i <= 1'b0;
    end
    repeat (2) @(negedge clk_i);
  endtask

  task automatic pins(input bit idl, input [5:0] ev);
    @(posedge clk_i);
    idle_i <= idl;
    channel_event_i <= ev;
  endtask

  // steps across an optional source burst plus cyc cycles after it; settles first
  task automatic span(input integer w, input integer n, input integer cyc, input [15:0] exp);
    reg [15:0] c0;
    reg [15:0] d;
    repeat (24) @(negedge clk_i);
    c0 = count_o;
    if (n > 0)
      src_u.burst(w, n);
    repeat (cyc) @(negedge clk_i);
    d = count_o - c0;
    chk(d, exp);
  endtask

  task automatic close_out;
    $display("mismatches %0d, comparisons %0d", bad_count, checks);
    if (bad_count == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // hang guard: the tests need some 1300 cycles
  initial begin
    #300000;
    bad_count = bad_count + 1;
    close_out;
  end

  // ==========================================================================
  // test sequence
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk(watchdog_mode_o, 1'b1);
    chk({irq_o, count_o}, 32'h0000_0000);
    rdchk(8'h20, 32'h0000_0000);
    wr(`CTA_OFS_CTRL, 32'h0000_000E);
    rdchk(`CTA_OFS_CTRL, 32'h0000_0100);
    xfer(1'b1, `CTA_OFS_CTRL, 4'h2, 32'h0000_0000);
    chk(watchdog_mode_o, 1'b0);
    // reserved code holds the count still
    wr(`CTA_OFS_CTRL, 32'h0000_000E);
    setc(16'h12FF);
    span(0, 0, 20, 16'h0000);
    chk(count_o, 16'h12FF);
    // snapshot stays while the counter moves on
    wr(`CTA_OFS_CTRL, 32'h0000_0004);
    rdchk(`CTA_OFS_COUNT_LOW, 32'h0000_00FF);
    tick0(1);
    rdchk(`CTA_OFS_COUNT_HIGH, 32'h0000_0012);
    rdchk(`CTA_OFS_COUNT_LOW, 32'h0000_0000);
    rdchk(`CTA_OFS_COUNT_HIGH, 32'h0000_0013);
    // clock timebases: ten steps in ten periods each, then oscillator and count-line bursts
    for (i = 0; i < 3; i = i + 1) begin
      wr(`CTA_OFS_CTRL, (i == 2) ? 32'h0000_0008 : i << 1);
      span(0, 0, (i == 0) ? 120 : ((i == 1) ? 40 : 10), 16'h000A);
    end
    wr(`CTA_OFS_CTRL, 32'h0000_000A);
    span(0, 64, 8, 16'h0008);
    wr(`CTA_OFS_CTRL, 32'h0000_000C);
    span(1, 64, 8, 16'h0008);
    wr(`CTA_OFS_CTRL, 32'h0000_0006);
    span(2, 5, 8, 16'h0005);
    // idle with and without suspension
    wr(`CTA_OFS_CTRL, 32'h0000_0009);
    pins(1'b1, 6'h00);
    span(0, 0, 10, 16'h0000);
    pins(1'b0, 6'h00);
    span(0, 0, 10, 16'h000A);
    wr(`CTA_OFS_CTRL, 32'h0000_0008);
    pins(1'b1, 6'h00);
    span(0, 0, 10, 16'h000A);
    pins(1'b0, 6'h00);
    // wrap with the request masked, then enabled, cleared and wrapped again
    wr(`CTA_OFS_CTRL, 32'h0000_0004);
    setc(16'hFFFE);
    tick0(2);
    chk(count_o, 16'h0000);
    rdchk(`CTA_OFS_FLAGS, 32'h0000_0003);
    chk(irq_o, 1'b0);
    wr(`CTA_OFS_CTRL, 32'h0000_0014);
    tick0(0);
    chk(irq_o, 1'b1);
    rdchk(`CTA_OFS_FLAGS, 32'h0000_0003);
    wr(`CTA_OFS_FLAGS, 32'h0000_0003);
    tick0(0);
    chk(irq_o, 1'b0);
    setc(16'hFFFF);
    tick0(1);
    chk(irq_o, 1'b1);
    // intermediate flag only on the carry out of the selected bit
    for (i = 0; i < 4; i = i + 1) begin
      wr(`CTA_OFS_CTRL, 32'h0000_0024 | (i << 6));
      wr(`CTA_OFS_FLAGS, 32'h0000_00FF);
      setc((16'h0001 << (7 + i)) - 16'h0001);
      tick0(1);
      rdchk(`CTA_OFS_FLAGS, 32'h0000_0000);
      setc((16'h0001 << (8 + i)) - 16'h0001);
      tick0(1);
      rdchk(`CTA_OFS_FLAGS, 32'h0000_0002);
      chk(irq_o, 1'b1);
    end
    // channel flags set with their enables off
    wr(`CTA_OFS_CTRL, 32'h0000_0004);
    wr(`CTA_OFS_FLAGS, 32'h0000_00FF);
    pins(1'b0, 6'h3F);
    pins(1'b0, 6'h00);
    rdchk(`CTA_OFS_FLAGS, 32'h0000_00FC);
    chk(irq_o, 1'b0);
    wr(`CTA_OFS_CH_ENABLE, 32'h0000_0001);
    tick0(0);
    chk(irq_o, 1'b1);
    wr(`CTA_OFS_FLAGS, 32'h0000_00FC);
    tick0(0);
    chk(irq_o, 1'b0);
    pins(1'b0, 6'h01);
    pins(1'b0, 6'h00);
    tick0(0);
    chk(irq_o, 1'b1);
    close_out;
  end
endmodule
